// [src/alu_status_pkg.sv]
package alu_status_pkg;
  localparam int          STAT_W        = 8;
  localparam int          BIT_CARRY     = 0;
  localparam int          BIT_NIBBLE    = 1;
  localparam int          BIT_ZERO      = 2;
  localparam int          BIT_SLEEP     = 3;
  localparam int          BIT_WDOG      = 4;
  localparam logic [7:0]  UNIMPL_MASK   = 8'hE0;
  localparam logic [7:0]  ARITH_MASK    = 8'h07;
  // Reset values: watchdog and sleep flags high at power-up, arithmetic flags clear
  localparam logic        RST_WDOG      = 1'b1;
  localparam logic        RST_SLEEP     = 1'b1;
  localparam logic [2:0]  RST_ARITH     = 3'h0;
  localparam logic [3:0]  NIBBLE_MASK   = 4'hF;

  // ALU operations; all but OP_NONE touch the flags
  typedef enum logic [5:0] {
    OP_NONE = 6'h01,
    OP_ADD  = 6'h02,
    OP_SUB  = 6'h04,
    OP_LOGIC = 6'h08,
    OP_RRC  = 6'h10,
    OP_RLC  = 6'h20
  } alu_op_t;
endpackage

// [src/flag_adder.sv]
`timescale 1ns/10ps
module flag_adder #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] op_a,
  input  wire logic [WIDTH-1:0] op_b,
  input  wire logic             sub,
  output logic      [WIDTH-1:0] sum,
  output logic                  nibble_cy,
  output logic                  msb_cy
);
  logic [WIDTH-1:0] b_eff;
  logic [4:0]       low_sum;
  logic [WIDTH:0]   full_sum;

  always_comb begin
    b_eff     = sub ? ~op_b : op_b;
    low_sum   = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
    full_sum  = {1'b0, op_a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, sub};
    sum       = full_sum[WIDTH-1:0];
    nibble_cy = low_sum[4];
    msb_cy    = full_sum[WIDTH];
  end
endmodule

// [src/alu_status_flags.sv]
`timescale 1ns/10ps
module alu_status_flags #(
  parameter int WIDTH = 8
) (
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  input  wire alu_status_pkg::alu_op_t alu_op,
  input  wire logic [WIDTH-1:0]      op_a,
  input  wire logic [WIDTH-1:0]      op_b,
  input  wire logic                  logic_zero,
  input  wire logic                  stat_wr,
  input  wire logic [7:0]            stat_wdata,
  input  wire logic                  watchdog_kick_instr,
  input  wire logic                  sleep_instr,
  input  wire logic                  watchdog_timer_expired,
  output logic [7:0]                 core_status_flags,
  output logic [WIDTH-1:0]           alu_result
);
  typedef struct packed {
    logic             wdog;
    logic             sleep;
    logic             zero;
    logic             nibble;
    logic             carry;
    logic [WIDTH-1:0] res;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [WIDTH-1:0] add_sum;
  logic             add_nib;
  logic             add_cy;
  logic [WIDTH-1:0] shift_res;
  logic             shift_out;

  // Subtraction reuses the adder with inverted operand plus one
  flag_adder #(.WIDTH(WIDTH)) flag_adder_inst (
    .op_a      (op_a),
    .op_b      (op_b),
    .sub       (alu_op == alu_status_pkg::OP_SUB),
    .sum       (add_sum),
    .nibble_cy (add_nib),
    .msb_cy    (add_cy)
  );

  always_comb begin
    nxt_st    = st_ff;
    shift_res = '0;
    shift_out = 1'b0;
    // A flag-affecting op disables the write to all three arithmetic bits, not only the ones it sets
    if (stat_wr && alu_op == alu_status_pkg::OP_NONE) begin
      nxt_st.zero   = stat_wdata[alu_status_pkg::BIT_ZERO];
      nxt_st.nibble = stat_wdata[alu_status_pkg::BIT_NIBBLE];
      nxt_st.carry  = stat_wdata[alu_status_pkg::BIT_CARRY];
    end
    case (alu_op)
      alu_status_pkg::OP_ADD,
      alu_status_pkg::OP_SUB: begin
        nxt_st.res    = add_sum;
        nxt_st.zero   = (add_sum == '0);
        nxt_st.nibble = add_nib;
        nxt_st.carry  = add_cy;
      end
      alu_status_pkg::OP_LOGIC: begin
        nxt_st.zero = logic_zero;
      end
      alu_status_pkg::OP_RRC: begin
        shift_res    = {st_ff.carry, op_a[WIDTH-1:1]};
        shift_out    = op_a[0];
        nxt_st.res   = shift_res;
        nxt_st.carry = shift_out;
      end
      alu_status_pkg::OP_RLC: begin
        shift_res    = {op_a[WIDTH-2:0], st_ff.carry};
        shift_out    = op_a[WIDTH-1];
        nxt_st.res   = shift_res;
        nxt_st.carry = shift_out;
      end
      default: begin
      end
    endcase
    // Expiry wins over a kick arriving in the same cycle so it is never lost
    if (watchdog_kick_instr) begin
      nxt_st.wdog  = 1'b1;
      nxt_st.sleep = 1'b1;
    end
    if (sleep_instr) begin
      nxt_st.wdog  = 1'b1;
      nxt_st.sleep = 1'b0;
    end
    if (watchdog_timer_expired) begin
      nxt_st.wdog = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff.wdog   <= alu_status_pkg::RST_WDOG;
      st_ff.sleep  <= alu_status_pkg::RST_SLEEP;
      st_ff.zero   <= alu_status_pkg::RST_ARITH[alu_status_pkg::BIT_ZERO];
      st_ff.nibble <= alu_status_pkg::RST_ARITH[alu_status_pkg::BIT_NIBBLE];
      st_ff.carry  <= alu_status_pkg::RST_ARITH[alu_status_pkg::BIT_CARRY];
      st_ff.res    <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    core_status_flags = {3'h0, st_ff.wdog, st_ff.sleep, st_ff.zero, st_ff.nibble, st_ff.carry};
    alu_result        = st_ff.res;
  end

  // Taken events; expiry outranks sleep and kick, so those steps exclude it
  sequence s_kick_taken;
    clk_en && watchdog_kick_instr && !sleep_instr && !watchdog_timer_expired;
  endsequence

  sequence s_sleep_taken;
    clk_en && sleep_instr && !watchdog_timer_expired;
  endsequence

  sequence s_expiry_taken;
    clk_en && watchdog_timer_expired;
  endsequence

  a_upper_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (core_status_flags & alu_status_pkg::UNIMPL_MASK) == 8'h00)
    else $error("Unimplemented status bits not zero");

  a_kick_sets: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_kick_taken |=> st_ff.wdog && st_ff.sleep)
    else $error("Watchdog kick did not set both flags");

  a_sleep_then_kick: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_sleep_taken ##1 s_kick_taken |=> st_ff.wdog && st_ff.sleep)
    else $error("Kick after sleep did not restore the flags");

  a_expiry_clears: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_expiry_taken |=> !st_ff.wdog)
    else $error("Watchdog expiry did not clear flag");

  a_sleep_sets: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_sleep_taken |=> st_ff.wdog)
    else $error("Sleep did not set the expiry flag");

  a_sleep_clears: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_sleep_taken |=> !st_ff.sleep)
    else $error("Sleep did not clear the sleep entry flag");

  a_add_carry: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && alu_op == alu_status_pkg::OP_ADD |=>
      st_ff.carry == (({1'b0, $past(op_a)} + {1'b0, $past(op_b)}) > 9'h0FF))
    else $error("Add carry wrong");

  a_add_nibble: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && alu_op == alu_status_pkg::OP_ADD |=>
      st_ff.nibble == (({1'b0, $past(op_a[3:0])} + {1'b0, $past(op_b[3:0])}) > 5'h0F))
    else $error("Add nibble carry wrong");

  a_sub_borrow: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && alu_op == alu_status_pkg::OP_SUB |=>
      st_ff.carry == ($past(op_a) >= $past(op_b))
      && st_ff.nibble == (($past(op_a) & alu_status_pkg::NIBBLE_MASK) >= ($past(op_b) & alu_status_pkg::NIBBLE_MASK)))
    else $error("Subtract borrow polarity wrong");

  a_sub_result: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && alu_op == alu_status_pkg::OP_SUB |=> alu_result == WIDTH'($past(op_a) - $past(op_b)))
    else $error("Subtract result wrong");

  a_zero_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && (alu_op == alu_status_pkg::OP_ADD || alu_op == alu_status_pkg::OP_SUB) |=>
      st_ff.zero == (($past(alu_op) == alu_status_pkg::OP_SUB) ? ($past(op_a) == $past(op_b))
                                                              : (WIDTH'($past(op_a) + $past(op_b)) == '0)))
    else $error("Zero flag mismatch");

  a_logic_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && alu_op == alu_status_pkg::OP_LOGIC |=> st_ff.zero == $past(logic_zero))
    else $error("Logic zero flag mismatch");

  a_rotate_right: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && alu_op == alu_status_pkg::OP_RRC |=> st_ff.carry == $past(op_a[0]))
    else $error("Rotate right carry wrong");

  a_rotate_left: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && alu_op == alu_status_pkg::OP_RLC |=> st_ff.carry == $past(op_a[WIDTH-1]))
    else $error("Rotate left carry wrong");

  a_rotate_result: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && alu_op == alu_status_pkg::OP_RRC |=> alu_result == {$past(st_ff.carry), $past(op_a[WIDTH-1:1])})
    else $error("Rotate right result wrong");

  a_write_ignored: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && stat_wr && alu_op == alu_status_pkg::OP_LOGIC |=> $stable(st_ff.nibble) && $stable(st_ff.carry))
    else $error("Write reached arithmetic bits during a flag operation");

  a_write_no_sleep: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && stat_wr && !watchdog_kick_instr && !sleep_instr && !watchdog_timer_expired |=>
      $stable(st_ff.wdog) && $stable(st_ff.sleep))
    else $error("Software write changed watchdog or sleep flag");

  a_write_lands: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && stat_wr && alu_op == alu_status_pkg::OP_NONE |=>
      (core_status_flags & alu_status_pkg::ARITH_MASK) == ($past(stat_wdata) & alu_status_pkg::ARITH_MASK))
    else $error("Plain write did not land in arithmetic bits");

  a_rotate_keeps: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && (alu_op == alu_status_pkg::OP_RRC || alu_op == alu_status_pkg::OP_RLC) |=>
      $stable(st_ff.zero) && $stable(st_ff.nibble))
    else $error("Rotate changed zero or nibble carry flag");

  a_idle_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && alu_op == alu_status_pkg::OP_NONE && !stat_wr |=> $stable(core_status_flags[2:0]))
    else $error("Arithmetic flags changed without cause");
endmodule

// [verif/wdog_model.sv]
`timescale 1ns/10ps
module wdog_model #(
  parameter int LIMIT = 40
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic run,
  input  wire logic kick,
  output logic      expired
);
  logic [7:0] cnt_ff;
  // One-cycle expiry pulse; a kick restarts the count so expiry never follows a kick directly
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff  <= 8'h00;
      expired <= 1'b0;
    end else begin
      expired <= run && !kick && (cnt_ff == 8'(LIMIT - 1));
      cnt_ff  <= (kick || !run || cnt_ff == 8'(LIMIT - 1)) ? 8'h00 : cnt_ff + 8'h01;
    end
  end
endmodule

// [verif/alu_status_flags_tb_top.sv]
`timescale 1ns/10ps
module alu_status_flags_tb_top;
  logic                    sys_clk, arst_n, clk_en, logic_zero, stat_wr, kick, sleep_i, wd_run, expired;
  alu_status_pkg::alu_op_t alu_op;
  logic [7:0]              op_a, op_b, stat_wdata, flags, result;
  int                      failures, n_tests, i;
  alu_status_flags alu_status_flags_inst (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .alu_op(alu_op), .op_a(op_a), .op_b(op_b), .logic_zero(logic_zero), .stat_wr(stat_wr),
    .stat_wdata(stat_wdata), .watchdog_kick_instr(kick), .sleep_instr(sleep_i),
    .watchdog_timer_expired(expired), .core_status_flags(flags), .alu_result(result));
  wdog_model wdog_model_inst (.sys_clk(sys_clk), .arst_n(arst_n), .run(wd_run), .kick(kick),
    .expired(expired));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // Drives one cycle, then checks both registered outputs one edge later
  task automatic op(input alu_status_pkg::alu_op_t o, input logic [7:0] a, b, ef, er);
    alu_op = o;
    op_a = a;
    op_b = b;
    @(posedge sys_clk);
    #1;
    alu_op = alu_status_pkg::OP_NONE;
    stat_wr = 1'b0;
    kick = 1'b0;
    sleep_i = 1'b0;
    clk_en = 1'b1;
    chk(ef, flags);
    chk(er, result);
  endtask
  task automatic t_arith;
    op(alu_status_pkg::OP_ADD, 8'hFF, 8'h01, 8'h1F, 8'h00);
    op(alu_status_pkg::OP_ADD, 8'h0F, 8'h01, 8'h1A, 8'h10);
    op(alu_status_pkg::OP_SUB, 8'h05, 8'h06, 8'h18, 8'hFF);
    op(alu_status_pkg::OP_SUB, 8'h06, 8'h06, 8'h1F, 8'h00);
    op(alu_status_pkg::OP_SUB, 8'h10, 8'h01, 8'h19, 8'h0F);
  endtask
  task automatic t_rotate;
    op(alu_status_pkg::OP_RRC, 8'h02, 8'h00, 8'h18, 8'h81);
    op(alu_status_pkg::OP_RLC, 8'h80, 8'h00, 8'h19, 8'h00);
  endtask
  task automatic t_write;
    logic_zero = 1'b1;
    op(alu_status_pkg::OP_LOGIC, 8'h00, 8'h00, 8'h1D, 8'h00);
    stat_wr = 1'b1;
    stat_wdata = 8'hFF;
    op(alu_status_pkg::OP_NONE, 8'h00, 8'h00, 8'h1F, 8'h00);
    stat_wr = 1'b1;
    stat_wdata = 8'h00;
    logic_zero = 1'b0;
    op(alu_status_pkg::OP_LOGIC, 8'h00, 8'h00, 8'h1B, 8'h00);
    stat_wr = 1'b1;
    op(alu_status_pkg::OP_ADD, 8'hFF, 8'h01, 8'h1F, 8'h00);
    clk_en = 1'b0;
    op(alu_status_pkg::OP_ADD, 8'h01, 8'h01, 8'h1F, 8'h00);
  endtask
  task automatic t_power;
    sleep_i = 1'b1;
    op(alu_status_pkg::OP_NONE, 8'h00, 8'h00, 8'h17, 8'h00);
    kick = 1'b1;
    op(alu_status_pkg::OP_NONE, 8'h00, 8'h00, 8'h1F, 8'h00);
    wd_run = 1'b1;
    for (i = 0; i < 60 && expired !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    wd_run = 1'b0;
    op(alu_status_pkg::OP_NONE, 8'h00, 8'h00, 8'h0F, 8'h00);
  endtask
  task automatic complete_run;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {arst_n, clk_en, logic_zero, stat_wr, kick, sleep_i, wd_run} = 7'h00;
    {op_a, op_b, stat_wdata} = 24'h000000;
    alu_op = alu_status_pkg::OP_NONE;
    repeat (16) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    clk_en = 1'b1;
    chk(8'h18, flags);
    t_arith();
    t_rotate();
    t_write();
    t_power();
    complete_run();
  end
  // Whole run needs well under 200 cycles
  initial begin
    #20000;
    failures++;
    complete_run();
  end
endmodule
